// ### logic/ata_exec_pkg.sv
package ata_exec_pkg;
  // wishbone byte offsets of the register words
  localparam logic [7:0] OFS_DATA    = 8'h00; // sector buffer window
  localparam logic [7:0] OFS_SUBCMD  = 8'h04; // write: subcommand, read: error
  localparam logic [7:0] OFS_COUNT   = 8'h08;
  localparam logic [7:0] OFS_ADDR_LO = 8'h0c;
  localparam logic [7:0] OFS_ADDR_MD = 8'h10;
  localparam logic [7:0] OFS_ADDR_HI = 8'h14;
  localparam logic [7:0] OFS_DRVHEAD = 8'h18;
  localparam logic [7:0] OFS_COMMAND = 8'h1c; // write: command, read: status
  localparam logic [7:0] OFS_IRQ_ST  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h24;
  localparam logic [7:0] OFS_FEAT    = 8'h28; // last subcommand and config value

  // command bytes
  localparam logic [7:0] CMD_READ_A   = 8'h20;
  localparam logic [7:0] CMD_READ_B   = 8'h21;
  localparam logic [7:0] CMD_VERIFY_A = 8'h40;
  localparam logic [7:0] CMD_VERIFY_B = 8'h41;
  localparam logic [3:0] CMD_RECAL_HI = 4'h1;
  localparam logic [3:0] CMD_SEEK_HI  = 4'h7;
  localparam logic [7:0] CMD_SENSE    = 8'h03;
  localparam logic [7:0] CMD_FEATURES = 8'hef;

  // extended error codes
  localparam logic [7:0] EXT_NONE      = 8'h00;
  localparam logic [7:0] EXT_SELF_OK   = 8'h01;
  localparam logic [7:0] EXT_MISC      = 8'h09;
  localparam logic [7:0] EXT_BAD_ADDR  = 8'h21;
  localparam logic [7:0] EXT_OVERFLOW  = 8'h2f;
  localparam logic [7:0] EXT_VOLT_A    = 8'h35;
  localparam logic [7:0] EXT_VOLT_B    = 8'h36;
  localparam logic [7:0] EXT_DIAG_FAIL = 8'h05;
  localparam logic [7:0] EXT_UNCORR    = 8'h11;
  localparam logic [7:0] EXT_CORR      = 8'h18;
  localparam logic [7:0] EXT_ID_NF     = 8'h10;
  localparam logic [7:0] EXT_SPARES    = 8'h3a;
  localparam logic [7:0] EXT_ABORT     = 8'h1f;
  localparam logic [7:0] EXT_FORMAT    = 8'h0c;
  localparam logic [7:0] EXT_WR_FAIL   = 8'h03;

  // drive/head fields
  localparam int DH_LINEAR_BIT = 6;
  localparam int DH_DRIVE_BIT  = 4;

  // status fields
  localparam int ST_OCCUPIED = 7;
  localparam int ST_READY    = 6;
  localparam int ST_REQUEST  = 3;
  localparam int ST_ERROR    = 0;

  // interrupt event bits
  localparam int IRQ_DEVICE = 0; // sector ready or non-read command complete
  localparam int IRQ_FAULT  = 1; // command ended with error

  // sector geometry
  localparam int          SECTOR_WORDS = 128; // 512 bytes as 32-bit words
  localparam int          WPTR_W       = 7;
  localparam logic [8:0]  FULL_COUNT   = 9'h100; // count of zero means this

  // reset values
  localparam logic [7:0]  RST_DRVHEAD = 8'ha0;
  localparam logic [7:0]  RST_COUNT   = 8'h01;
  localparam logic [7:0]  RST_ADDR_LO = 8'h01;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_XFER  = 4'b0100,
    ST_DONE  = 4'b1000
  } exec_state_e;
endpackage

// ### logic/ata_cmd_exec.sv
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ata_cmd_exec
  import ata_exec_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // media read port
  input  wire logic [27:0] capacity_i,
  output logic             media_req_o,
  output logic      [27:0] media_lba_o,
  input  wire logic        media_valid_i,
  input  wire logic [31:0] media_data_i,
  input  wire logic        media_err_i,
  input  wire logic [7:0]  media_code_i,
  // interrupt and status
  output logic             irq_o,
  output logic             occupied_o,
  output logic             transfer_request_o
);

  typedef struct packed {
    exec_state_e          state;
    logic                 ack;
    logic [31:0]          rdata;
    logic [7:0]           drive_head_select;
    logic [7:0]           address_high_byte;
    logic [7:0]           address_mid_byte;
    logic [7:0]           address_low_byte;
    logic [7:0]           transfer_count;
    logic [7:0]           subcommand_select;
    logic [7:0]           feat_sel;
    logic [7:0]           feat_val;
    logic [7:0]           error_reg;
    logic [7:0]           last_code;
    logic                 err_flag;
    logic                 verify;
    logic [8:0]           remain;
    logic [WPTR_W-1:0]    wptr;
    logic                 sect_err;
    logic [7:0]           sect_code;
    logic [1:0]           irq_stat;
    logic [1:0]           irq_mask;
  } exec_s;

  exec_s       cur_ff;
  exec_s       nxt_cur;
  logic [31:0] sector_buf [SECTOR_WORDS];

  // address assembled from the task registers
  function automatic logic [27:0] lba_of(input logic [7:0] dh, input logic [7:0] hi,
                                         input logic [7:0] md, input logic [7:0] lo);
    lba_of = {dh[3:0], hi, md, lo};
  endfunction

  // range check: beyond capacity, or sector zero in geometry mode
  function automatic logic addr_bad(input logic [7:0] dh, input logic [27:0] linear_addr_select,
                                    input logic [27:0] cap, input logic [7:0] lo);
    addr_bad = (linear_addr_select >= cap) || (!dh[DH_LINEAR_BIT] && (lo == 8'h00));
  endfunction

  logic        acc;
  logic        wr;
  logic [27:0] cur_lba;
  logic [27:0] next_lba;
  logic [7:0]  cmd;
  logic        last_word;
  logic        sector_full;
  logic [8:0]  req_count;

  assign acc         = wb_cyc_i && wb_stb_i && !cur_ff.ack;
  assign wr          = acc && wb_we_i && wb_sel_i[0];
  assign cmd         = wb_dat_i[7:0];
  assign cur_lba     = lba_of(cur_ff.drive_head_select, cur_ff.address_high_byte,
                              cur_ff.address_mid_byte, cur_ff.address_low_byte);
  assign next_lba    = cur_lba + 28'h0000001;
  assign last_word   = (cur_ff.wptr == WPTR_W'(SECTOR_WORDS - 1));
  assign sector_full = media_valid_i && last_word;
  assign req_count   = (cur_ff.transfer_count == 8'h00) ? FULL_COUNT
                                                        : {1'b0, cur_ff.transfer_count};

  // next-state logic for bus, task file and command sequencing
  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.ack   = acc;
    // register writes, task file held while occupied
    if (wr) begin
      unique case (wb_adr_i)
        OFS_IRQ_ST:  nxt_cur.irq_stat = cur_ff.irq_stat & ~wb_dat_i[1:0];
        OFS_IRQ_MSK: nxt_cur.irq_mask = wb_dat_i[1:0];
        default: begin
          if (cur_ff.state == ST_IDLE || cur_ff.state == ST_DONE) begin
            unique case (wb_adr_i)
              OFS_SUBCMD:  nxt_cur.subcommand_select = cmd;
              OFS_COUNT:   nxt_cur.transfer_count    = cmd;
              OFS_ADDR_LO: nxt_cur.address_low_byte  = cmd;
              OFS_ADDR_MD: nxt_cur.address_mid_byte  = cmd;
              OFS_ADDR_HI: nxt_cur.address_high_byte = cmd;
              OFS_DRVHEAD: nxt_cur.drive_head_select = cmd;
              default: ;
            endcase
          end
        end
      endcase
    end
    // register reads, data window advances the buffer pointer during transfer
    if (acc && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_DATA: begin
          nxt_cur.rdata = sector_buf[cur_ff.wptr];
          if (cur_ff.state == ST_XFER) begin
            nxt_cur.wptr = cur_ff.wptr + WPTR_W'(1);
          end
        end
        OFS_SUBCMD:  nxt_cur.rdata = {24'h000000, cur_ff.error_reg};
        OFS_COUNT:   nxt_cur.rdata = {24'h000000, cur_ff.transfer_count};
        OFS_ADDR_LO: nxt_cur.rdata = {24'h000000, cur_ff.address_low_byte};
        OFS_ADDR_MD: nxt_cur.rdata = {24'h000000, cur_ff.address_mid_byte};
        OFS_ADDR_HI: nxt_cur.rdata = {24'h000000, cur_ff.address_high_byte};
        OFS_DRVHEAD: nxt_cur.rdata = {24'h000000, cur_ff.drive_head_select};
        OFS_COMMAND: nxt_cur.rdata = {24'h000000, (cur_ff.state == ST_FETCH),
                                      1'b1, 2'b00, (cur_ff.state == ST_XFER),
                                      2'b00, cur_ff.err_flag};
        OFS_IRQ_ST:  nxt_cur.rdata = {30'h00000000, cur_ff.irq_stat};
        OFS_IRQ_MSK: nxt_cur.rdata = {30'h00000000, cur_ff.irq_mask};
        OFS_FEAT:    nxt_cur.rdata = {16'h0000, cur_ff.feat_val, cur_ff.feat_sel};
        default:     nxt_cur.rdata = 32'h00000000;
      endcase
    end

    unique case (cur_ff.state)
      ST_IDLE, ST_DONE: begin
        if (wr && wb_adr_i == OFS_COMMAND) begin
          nxt_cur.err_flag  = 1'b0;
          nxt_cur.error_reg = 8'h00;
          nxt_cur.wptr      = '0;
          nxt_cur.state     = ST_DONE;
          if (cmd == CMD_READ_A || cmd == CMD_READ_B ||
              cmd == CMD_VERIFY_A || cmd == CMD_VERIFY_B) begin
            nxt_cur.verify = (cmd == CMD_VERIFY_A || cmd == CMD_VERIFY_B);
            nxt_cur.remain = req_count;
            if (addr_bad(cur_ff.drive_head_select, cur_lba, capacity_i,
                         cur_ff.address_low_byte)) begin
              nxt_cur.err_flag  = 1'b1;
              nxt_cur.error_reg = EXT_BAD_ADDR;
              nxt_cur.last_code = EXT_BAD_ADDR;
              nxt_cur.irq_stat  = cur_ff.irq_stat | 2'b11;
            end else begin
              nxt_cur.sect_err = 1'b0;
              nxt_cur.state    = ST_FETCH;
            end
          end else if (cmd[7:4] == CMD_RECAL_HI) begin
            nxt_cur.last_code = EXT_NONE;
            nxt_cur.irq_stat[IRQ_DEVICE] = 1'b1;
          end else if (cmd[7:4] == CMD_SEEK_HI) begin
            if (addr_bad(cur_ff.drive_head_select, cur_lba, capacity_i,
                         8'h01)) begin
              nxt_cur.err_flag  = 1'b1;
              nxt_cur.error_reg = EXT_BAD_ADDR;
              nxt_cur.last_code = EXT_BAD_ADDR;
              nxt_cur.irq_stat  = cur_ff.irq_stat | 2'b11;
            end else begin
              nxt_cur.last_code = EXT_NONE;
              nxt_cur.irq_stat[IRQ_DEVICE] = 1'b1;
            end
          end else if (cmd == CMD_SENSE) begin
            nxt_cur.error_reg = cur_ff.last_code;
            nxt_cur.last_code = EXT_NONE;
            nxt_cur.irq_stat[IRQ_DEVICE] = 1'b1;
          end else if (cmd == CMD_FEATURES) begin
            nxt_cur.feat_sel  = cur_ff.subcommand_select;
            nxt_cur.feat_val  = cur_ff.transfer_count;
            nxt_cur.last_code = EXT_NONE;
            nxt_cur.irq_stat[IRQ_DEVICE] = 1'b1;
          end else begin
            // unknown command aborts
            nxt_cur.err_flag  = 1'b1;
            nxt_cur.error_reg = EXT_ABORT;
            nxt_cur.last_code = EXT_ABORT;
            nxt_cur.irq_stat  = cur_ff.irq_stat | 2'b11;
          end
        end
      end
      ST_FETCH: begin
        // buffer fill from media, one word per valid beat
        if (media_valid_i) begin
          nxt_cur.wptr = cur_ff.wptr + WPTR_W'(1);
          if (media_err_i && !cur_ff.sect_err) begin
            nxt_cur.sect_err  = 1'b1;
            nxt_cur.sect_code = media_code_i;
          end
        end
        if (sector_full) begin
          nxt_cur.wptr     = '0;
          nxt_cur.sect_err = 1'b0;
          if (cur_ff.sect_err || media_err_i) begin
            // stop here; address registers still name this sector
            nxt_cur.state     = ST_DONE;
            nxt_cur.err_flag  = 1'b1;
            nxt_cur.error_reg = cur_ff.sect_err ? cur_ff.sect_code : media_code_i;
            nxt_cur.last_code = nxt_cur.error_reg;
            nxt_cur.irq_stat  = cur_ff.irq_stat | 2'b11;
            if (cur_ff.verify) begin
              nxt_cur.transfer_count = cur_ff.remain[7:0];
            end
          end else if (cur_ff.verify) begin
            nxt_cur.remain = cur_ff.remain - 9'h001;
            if (cur_ff.remain == 9'h001) begin
              nxt_cur.state     = ST_DONE;
              nxt_cur.last_code = EXT_NONE;
              nxt_cur.irq_stat[IRQ_DEVICE] = 1'b1;
            end else begin
              {nxt_cur.drive_head_select[3:0], nxt_cur.address_high_byte,
               nxt_cur.address_mid_byte, nxt_cur.address_low_byte} = next_lba;
            end
          end else begin
            nxt_cur.state = ST_XFER;
            nxt_cur.irq_stat[IRQ_DEVICE] = 1'b1;
          end
        end
      end
      ST_XFER: begin
        // host drains the sector through the data window
        if (acc && !wb_we_i && wb_adr_i == OFS_DATA && last_word) begin
          nxt_cur.wptr   = '0;
          nxt_cur.remain = cur_ff.remain - 9'h001;
          if (cur_ff.remain == 9'h001) begin
            nxt_cur.state     = ST_DONE;
            nxt_cur.last_code = EXT_NONE;
          end else begin
            {nxt_cur.drive_head_select[3:0], nxt_cur.address_high_byte,
             nxt_cur.address_mid_byte, nxt_cur.address_low_byte} = next_lba;
            nxt_cur.state = ST_FETCH;
          end
        end
      end
      default: nxt_cur.state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff                   <= '0;
      cur_ff.state             <= ST_IDLE;
      cur_ff.drive_head_select <= RST_DRVHEAD;
      cur_ff.transfer_count    <= RST_COUNT;
      cur_ff.address_low_byte  <= RST_ADDR_LO;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // sector buffer fill; contents survive an error for the host
  always_ff @(posedge clk_i) begin
    if (cur_ff.state == ST_FETCH && media_valid_i) begin
      sector_buf[cur_ff.wptr] <= media_data_i;
    end
  end

  // outputs
  assign wb_dat_o           = cur_ff.rdata;
  assign wb_ack_o           = cur_ff.ack;
  assign media_req_o        = (cur_ff.state == ST_FETCH);
  assign media_lba_o        = cur_lba;
  assign occupied_o         = (cur_ff.state == ST_FETCH);
  assign transfer_request_o = (cur_ff.state == ST_XFER) && !cur_ff.verify;
  assign irq_o              = |(cur_ff.irq_stat & cur_ff.irq_mask);

endmodule
`default_nettype wire

// ### testbench/media_model.sv
`timescale 1ns/1ps
`default_nettype none
module media_model (
  // clock
  input  wire logic        clk_i,
  // fetch request from the device
  input  wire logic        media_req_i,
  input  wire logic [27:0] media_lba_i,
  // scenario controls
  input  wire logic        slow_i,
  input  wire logic [27:0] bad_lba_i,
  // word stream back to the device
  output logic             media_valid_o,
  output logic      [31:0] media_data_o,
  output logic             media_err_o,
  output logic      [7:0]  media_code_o
);
  logic [7:0]  idx = 8'h00;
  logic        gap = 1'b0;
  logic [31:0] word;
  // word index and half-rate pacing
  always @(posedge clk_i) begin
    gap <= slow_i & ~gap;
    if (!media_req_i) idx <= 8'h00;
    else if (media_valid_o) idx <= (idx == 8'h7f) ? 8'h00 : idx + 8'h01; // next sector restarts
  end
  // 128 words a sector; data shows inverted outside a beat
  assign word          = {media_lba_i[19:0], 5'h00, idx[6:0]};
  assign media_valid_o = media_req_i & ~idx[7] & ~gap;
  assign media_data_o  = media_valid_o ? word : ~word;
  assign media_err_o   = media_valid_o && media_lba_i == bad_lba_i && idx == 8'h05;
  assign media_code_o  = 8'h11; // uncorrectable data fault
endmodule
`default_nettype wire

// ### testbench/ata_read_verify_command_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ata_read_verify_command_exec_checker
  import ata_exec_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_ack_o,
  // media and flags
  input wire logic        media_req_o,
  input wire logic [27:0] media_lba_o,
  input wire logic        media_valid_i,
  input wire logic        occupied_o,
  input wire logic        transfer_request_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [8:0] words_ff;
  // words delivered into the sector being filled
  always_ff @(posedge clk_i) begin
    if (rst_i || !media_req_o) words_ff <= 9'h000;
    else if (media_valid_i) words_ff <= words_ff[7] ? 9'h001 : words_ff + 9'h001;
  end
  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_latency_a: assert property (taken_s |=> answer_s) else $error("ack late or long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  request_idle_a: assert property (transfer_request_o |-> !occupied_o && !media_req_o)
    else $error("request while occupied");
  fill_busy_a: assert property ($rose(transfer_request_o) |-> $past(occupied_o))
    else $error("request without fill");
  sector_words_a: assert property ($rose(transfer_request_o) |-> words_ff == 9'h080)
    else $error("request before full sector");
  lba_steady_a: assert property (
    media_req_o && $past(media_req_o) && words_ff != 9'h080 |-> $stable(media_lba_o))
    else $error("address moved in fill");
  verify_step_a: assert property (
    media_req_o && words_ff == 9'h080 && $past(words_ff) == 9'h07f |->
    media_lba_o == $past(media_lba_o) + 28'h0000001) else $error("verify step not consecutive");
  occupied_cause_a: assert property ($rose(occupied_o) |->
    $past(wb_cyc_i && wb_stb_i && (wb_adr_i == OFS_COMMAND || wb_adr_i == OFS_DATA)))
    else $error("busy without cause");
  next_fetch_a: assert property ($fell(transfer_request_o) && occupied_o |->
    media_lba_o == $past(media_lba_o) + 28'h0000001) else $error("next sector not consecutive");
endmodule
`default_nettype wire

// ### testbench/ata_read_verify_command_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ata_read_verify_command_exec_tb_top;
  import ata_exec_pkg::*;
  typedef struct packed {logic [7:0] cmd; logic [27:0] linear_addr_select; logic err; logic [7:0] code;} row_s;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow, saw_bad;
  logic        media_req_o, media_valid_i, media_err_i, irq_o, occupied_o, transfer_request_o;
  logic [7:0]  wb_adr_i, media_code_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, media_data_i, rd;
  logic [27:0] capacity_i, media_lba_o, bad_lba;
  int          failures, num_checks, cycles, words;
  // immediate commands: command, address, error flag, sense code
  row_s rows [6] = '{'{8'h70, 28'h000000a, 1'b0, 8'h00}, '{8'h7f, 28'h00003e8, 1'b1, 8'h21},
                     '{8'h10, 28'h0001388, 1'b0, 8'h00}, '{8'h1f, 28'h00003e8, 1'b0, 8'h00},
                     '{8'hef, 28'h000000a, 1'b0, 8'h00}, '{8'h00, 28'h000000a, 1'b1, 8'h1f}};
  ata_cmd_exec ata_cmd_exec_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .capacity_i, .media_req_o, .media_lba_o,
    .media_valid_i, .media_data_i, .media_err_i, .media_code_i, .irq_o, .occupied_o,
    .transfer_request_o);
  media_model media_model_inst (.clk_i, .media_req_i(media_req_o), .media_lba_i(media_lba_o),
    .slow_i(slow), .bad_lba_i(bad_lba), .media_valid_o(media_valid_i),
    .media_data_o(media_data_i), .media_err_o(media_err_i), .media_code_o(media_code_i));
  // clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one classic single cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic set_tf(input logic [7:0] cnt, input logic [27:0] linear_addr_select, input logic [7:0] cmd);
    bus(1'b1, OFS_COUNT, {24'h0, cnt});
    bus(1'b1, OFS_ADDR_LO, {24'h0, linear_addr_select[7:0]});
    bus(1'b1, OFS_ADDR_MD, {24'h0, linear_addr_select[15:8]});
    bus(1'b1, OFS_ADDR_HI, {24'h0, linear_addr_select[23:16]});
    bus(1'b1, OFS_DRVHEAD, {24'h0, 4'he, linear_addr_select[27:24]});
    bus(1'b1, OFS_COMMAND, {24'h0, cmd});
  endtask
  task automatic sense(input logic [7:0] code);
    bus(1'b1, OFS_COMMAND, {24'h0, CMD_SENSE});
    bus(1'b0, OFS_SUBCMD, 32'h0);
    check(rd & 32'hff, {24'h0, code});
    bus(1'b1, OFS_IRQ_ST, 32'h3);
  endtask
  // wait for data request, or for the busy flag to drop; the cycle ceiling bounds it
  task automatic wait_until(input logic want_req);
    repeat (3) @(posedge clk_i);
    while ((want_req ? transfer_request_o : ~occupied_o) !== 1'b1) begin
      @(posedge clk_i);
    end
  endtask
  task automatic read_sector(input logic [27:0] linear_addr_select);
    for (int i = 0; i < 128; i++) begin
      bus(1'b0, OFS_DATA, 32'h0);
      check(rd, {linear_addr_select[19:0], 5'h00, i[6:0]});
    end
  endtask
  // cycle ceiling, media beats and flags seen during verify
  always @(posedge clk_i) begin
    cycles++;
    if (media_req_o === 1'b1 && media_valid_i === 1'b1) words++;
    if (transfer_request_o === 1'b1 || (occupied_o === 1'b1 && irq_o === 1'b1)) saw_bad = 1'b1;
    if (cycles == 60000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, slow} = 5'b10000;
    {wb_adr_i, wb_dat_i, failures, num_checks, cycles, words} = '0;
    wb_sel_i = 4'hf;
    capacity_i = 28'h00003e8;
    bad_lba = 28'hfffffff;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, OFS_IRQ_MSK, 32'h3);
    foreach (rows[i]) begin
      set_tf(8'h01, rows[i].linear_addr_select, rows[i].cmd);
      bus(1'b0, OFS_COMMAND, 32'h0);
      check(rd & 32'hc9, 32'h40 | rows[i].err);
      check(irq_o, 1'b1);
      bus(1'b0, OFS_IRQ_ST, 32'h0);
      check(rd, {rows[i].err, 1'b1});
      bus(1'b1, OFS_IRQ_ST, 32'h3);
      sense(rows[i].code);
      $display("row %0d done", i);
    end
    // geometry mode with sector zero is an invalid address
    bus(1'b1, OFS_DRVHEAD, 32'ha0);
    bus(1'b1, OFS_ADDR_LO, 32'h00);
    bus(1'b1, OFS_COMMAND, {24'h0, CMD_READ_A});
    bus(1'b0, OFS_COMMAND, 32'h0);
    check(rd & 32'h89, 32'h01);
    sense(EXT_BAD_ADDR);
    $display("geometry test done");
    bus(1'b1, OFS_SUBCMD, 32'h05);
    set_tf(8'hfe, 28'h000000a, CMD_FEATURES);
    bus(1'b0, OFS_FEAT, 32'h0);
    check(rd, 32'h0000fe05);
    bus(1'b1, OFS_IRQ_ST, 32'h3);
    $display("features test done");
    for (int c = 0; c < 2; c++) begin
      slow = c[0];
      set_tf(8'h02, 28'h0000100, c ? CMD_READ_B : CMD_READ_A);
      for (int s = 0; s < 2; s++) begin
        wait_until(1'b1);
        check(irq_o, 1'b1);
        bus(1'b1, OFS_IRQ_ST, 32'h3);
        read_sector(28'h0000100 + s);
      end
      repeat (3) @(posedge clk_i);
      check({occupied_o, transfer_request_o, irq_o}, 3'b000);
      $display("read test %0d done", c);
    end
    bad_lba = 28'h0000201;
    set_tf(8'h03, 28'h0000200, CMD_READ_A);
    wait_until(1'b1);
    read_sector(28'h0000200);
    wait_until(1'b0);
    bus(1'b0, OFS_COMMAND, 32'h0);
    check(rd & 32'h89, 32'h01);
    bus(1'b0, OFS_ADDR_LO, 32'h0);
    check(rd, 32'h01);
    bus(1'b0, OFS_ADDR_MD, 32'h0);
    check(rd, 32'h02);
    bus(1'b0, OFS_DATA, 32'h0);
    check(rd, {20'h00201, 12'h000});
    sense(EXT_UNCORR);
    $display("read error test done");
    saw_bad = 1'b0;
    slow = 1'b0;
    words = 0;
    set_tf(8'h00, 28'h0000000, CMD_VERIFY_A);
    wait_until(1'b0);
    check(words, 32'h8000);
    check({saw_bad, irq_o}, 2'b01);
    bus(1'b1, OFS_IRQ_ST, 32'h3);
    bad_lba = 28'h0000302;
    set_tf(8'h05, 28'h0000300, CMD_VERIFY_B);
    wait_until(1'b0);
    bus(1'b0, OFS_COUNT, 32'h0);
    check(rd, 32'h03);
    bus(1'b0, OFS_ADDR_LO, 32'h0);
    check(rd, 32'h02);
    bus(1'b0, OFS_IRQ_ST, 32'h0);
    check(rd, 32'h3);
    sense(EXT_UNCORR);
    $display("verify tests done");
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, OFS_COUNT, 32'h0);
    check(rd, 32'h01);
    bus(1'b0, OFS_DRVHEAD, 32'h0);
    check(rd, 32'ha0);
    bus(1'b0, OFS_ADDR_HI, 32'h0);
    check(rd, 32'h00);
    bus(1'b0, OFS_IRQ_MSK, 32'h0);
    check(rd, 32'h00);
    bus(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h00);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
bind ata_cmd_exec ata_read_verify_command_exec_checker ata_read_verify_command_exec_checker_inst (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_ack_o, .media_req_o, .media_lba_o,
  .media_valid_i, .occupied_o, .transfer_request_o);
`default_nettype wire
